// ---- logic/cpc_pkg.sv ----
package cpc_pkg;

  // Register map
  localparam logic [4:0] CPC_OFFSET_CTRL_ONE = 5'h10;

  // Field positions
  localparam int CPC_BIT_NO_PULSE    = 15;
  localparam int CPC_POS_DS_COUNT    = 12;
  localparam int CPC_BIT_DS_ENABLE   = 11;
  localparam int CPC_BIT_FORCE_LINK  = 10;
  localparam int CPC_POS_CABLE_DET   = 8;
  localparam int CPC_BIT_EXT_DIST    = 7;
  localparam int CPC_POS_XOVER       = 5;
  localparam int CPC_BIT_RSVD        = 4;
  localparam int CPC_BIT_TX_DISABLE  = 3;
  localparam int CPC_BIT_POWER_DOWN  = 2;
  localparam int CPC_BIT_POL_DISABLE = 1;
  localparam int CPC_BIT_NO_JABBER   = 0;

  // Reset values
  localparam logic [2:0] CPC_DS_COUNT_RESET  = 3'h3;
  localparam logic       CPC_DS_ENABLE_RESET = 1'b0;
  localparam logic [1:0] CPC_XOVER_STRAP_LO  = 2'h1;
  localparam logic [1:0] CPC_XOVER_STRAP_HI  = 2'h3;

  // Timing: edges after reset release before the straps are taken
  localparam logic [2:0] CPC_STRAP_SETTLE = 3'h4;

  // Crossover codes
  localparam logic [1:0] CPC_XOVER_MDI  = 2'h0;
  localparam logic [1:0] CPC_XOVER_MDIX = 2'h1;
  localparam logic [1:0] CPC_XOVER_AUTO = 2'h3;

  // Configuration that reaches the link units
  typedef struct packed {
    logic       link_pulse_enable;
    logic [2:0] downshift_attempts;
    logic       downshift_enable;
    logic       force_link_good;
    logic       cable_detect_enable;
    logic       cable_detect_pulse;
    logic       low_rx_threshold;
    logic [1:0] crossover_mode;
    logic       tx_disable;
    logic       power_down;
    logic       polarity_fix_disable;
    logic       jabber_enable;
  } cpc_config_type;

endpackage : cpc_pkg

// ---- logic/cpc_copper_control.sv ----
// Local design decision: the address-and-strobe port.
module cpc_copper_control (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Register port
  input  wire logic [4:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [15:0]             reg_rdata,
  // Straps
  input  wire logic                    cable_sleep_inhibit_strap,
  input  wire logic                    auto_crossover_strap,
  // Base control and link state
  input  wire logic                    base_power_down,
  input  wire logic                    soft_reset_request,
  input  wire logic                    link_is_gigabit,
  input  wire logic                    link_is_10_half,
  input  wire logic                    link_state_up,
  // Configuration to link units
  output cpc_pkg::cpc_config_type      config_out,
  output logic                         link_up,
  output logic                         port_powered_down,
  output logic                         soft_reset_pulse,
  output logic                         aneg_restart_pulse
);

  // Strap and base-power-down pin synchronisers
  logic [2:0] sleep_sync_reg;
  logic [2:0] sleep_sync_next;
  logic [2:0] xc_sync_reg;
  logic [2:0] xc_sync_next;
  logic [2:0] pd_sync_reg;
  logic [2:0] pd_sync_next;
  logic       sleep_lvl_reg;
  logic       sleep_lvl_next;
  logic       xc_lvl_reg;
  logic       xc_lvl_next;
  logic       pd_lvl_reg;
  logic       pd_lvl_next;

  // Register image, active copies of update fields
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [2:0]  ds_cnt_act_reg;
  logic [2:0]  ds_cnt_act_next;
  logic        ds_en_act_reg;
  logic        ds_en_act_next;
  logic [1:0]  cable_act_reg;
  logic [1:0]  cable_act_next;
  logic [1:0]  xover_act_reg;
  logic [1:0]  xover_act_next;

  // Strap capture after reset release
  logic        strap_done_reg;
  logic        strap_done_next;
  logic [2:0]  settle_reg;
  logic [2:0]  settle_next;

  // Power state and read data
  logic        pd_prev_reg;
  logic        pd_prev_next;
  logic        wake_pulse_reg;
  logic        wake_pulse_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  logic        hit;
  logic        powered_down;
  logic        do_soft_reset;
  logic [1:0]  strap_xover;

  assign hit = reg_addr == cpc_pkg::CPC_OFFSET_CTRL_ONE;
  assign powered_down = ctrl_reg[cpc_pkg::CPC_BIT_POWER_DOWN]
                        | pd_lvl_reg;
  assign do_soft_reset = soft_reset_request | wake_pulse_reg;
  assign strap_xover = xc_lvl_reg ? cpc_pkg::CPC_XOVER_STRAP_HI
                                  : cpc_pkg::CPC_XOVER_STRAP_LO;

  always_comb begin
    sleep_sync_next = {sleep_sync_reg[1:0], cable_sleep_inhibit_strap};
    xc_sync_next    = {xc_sync_reg[1:0], auto_crossover_strap};
    pd_sync_next    = {pd_sync_reg[1:0], base_power_down};
    // Change counts only once stages two and three agree
    sleep_lvl_next  = (sleep_sync_reg[1] == sleep_sync_reg[2])
                      ? sleep_sync_reg[2] : sleep_lvl_reg;
    xc_lvl_next     = (xc_sync_reg[1] == xc_sync_reg[2])
                      ? xc_sync_reg[2] : xc_lvl_reg;
    pd_lvl_next     = (pd_sync_reg[1] == pd_sync_reg[2])
                      ? pd_sync_reg[2] : pd_lvl_reg;
  end

  always_comb begin
    ctrl_next       = ctrl_reg;
    ds_cnt_act_next = ds_cnt_act_reg;
    ds_en_act_next  = ds_en_act_reg;
    cable_act_next  = cable_act_reg;
    xover_act_next  = xover_act_reg;
    settle_next     = settle_reg;
    strap_done_next = strap_done_reg;
    // Straps sampled only after the level stage has settled,
    // else the reset value of the level flop would be captured
    if (!strap_done_reg) begin
      if (settle_reg != cpc_pkg::CPC_STRAP_SETTLE) begin
        settle_next = settle_reg + 3'h1;
      end else begin
        strap_done_next = 1'b1;
        ctrl_next[cpc_pkg::CPC_POS_CABLE_DET +: 2] =
          {2{~sleep_lvl_reg}};
        ctrl_next[cpc_pkg::CPC_POS_XOVER +: 2] = strap_xover;
        cable_act_next = {2{~sleep_lvl_reg}};
        xover_act_next = strap_xover;
      end
    end else if (reg_write && hit) begin
      ctrl_next = reg_wdata;
    end else if (do_soft_reset) begin
      // Soft reset: clear bit 15, latch update fields, retain the rest
      ctrl_next[cpc_pkg::CPC_BIT_NO_PULSE] = 1'b0;
      ds_cnt_act_next = ctrl_reg[cpc_pkg::CPC_POS_DS_COUNT +: 3];
      ds_en_act_next  = ctrl_reg[cpc_pkg::CPC_BIT_DS_ENABLE];
      cable_act_next  = ctrl_reg[cpc_pkg::CPC_POS_CABLE_DET +: 2];
      xover_act_next  = ctrl_reg[cpc_pkg::CPC_POS_XOVER +: 2];
    end
  end

  always_comb begin
    pd_prev_next    = powered_down;
    // Falling edge of combined power down
    wake_pulse_next = pd_prev_reg & ~powered_down;
    rdata_next      = (reg_read && hit) ? ctrl_reg : 16'h0000;
  end

  // Synchroniser group
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_sync_reg <= 3'h0;
      xc_sync_reg    <= 3'h0;
      pd_sync_reg    <= 3'h0;
      sleep_lvl_reg  <= 1'b0;
      xc_lvl_reg     <= 1'b0;
      pd_lvl_reg     <= 1'b0;
    end else begin
      sleep_sync_reg <= sleep_sync_next;
      xc_sync_reg    <= xc_sync_next;
      pd_sync_reg    <= pd_sync_next;
      sleep_lvl_reg  <= sleep_lvl_next;
      xc_lvl_reg     <= xc_lvl_next;
      pd_lvl_reg     <= pd_lvl_next;
    end
  end

  // Register image and active copies
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg       <= {4'h0, 1'b0, 11'h0} |
                        (16'(cpc_pkg::CPC_DS_COUNT_RESET)
                         << cpc_pkg::CPC_POS_DS_COUNT);
      ds_cnt_act_reg <= cpc_pkg::CPC_DS_COUNT_RESET;
      ds_en_act_reg  <= cpc_pkg::CPC_DS_ENABLE_RESET;
      cable_act_reg  <= 2'h0;
      xover_act_reg  <= cpc_pkg::CPC_XOVER_STRAP_LO;
    end else begin
      ctrl_reg       <= ctrl_next;
      ds_cnt_act_reg <= ds_cnt_act_next;
      ds_en_act_reg  <= ds_en_act_next;
      cable_act_reg  <= cable_act_next;
      xover_act_reg  <= xover_act_next;
    end
  end

  // Strap capture sequencing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_reg <= 1'b0;
      settle_reg     <= 3'h0;
    end else begin
      strap_done_reg <= strap_done_next;
      settle_reg     <= settle_next;
    end
  end

  // Power edge detect and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pd_prev_reg    <= 1'b0;
      wake_pulse_reg <= 1'b0;
      rdata_reg      <= 16'h0000;
    end else begin
      pd_prev_reg    <= pd_prev_next;
      wake_pulse_reg <= wake_pulse_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  always_comb begin
    config_out.link_pulse_enable =
      ~ctrl_reg[cpc_pkg::CPC_BIT_NO_PULSE];
    config_out.downshift_attempts = ds_cnt_act_reg;
    config_out.downshift_enable   = ds_en_act_reg;
    config_out.force_link_good =
      ctrl_reg[cpc_pkg::CPC_BIT_FORCE_LINK] & ~link_is_gigabit;
    config_out.cable_detect_enable = cable_act_reg[1];
    config_out.cable_detect_pulse  = &cable_act_reg;
    config_out.low_rx_threshold =
      ctrl_reg[cpc_pkg::CPC_BIT_EXT_DIST];
    // Reserved code 10 treated as automatic, the safest fallback
    config_out.crossover_mode = (xover_act_reg == 2'h2)
                                ? cpc_pkg::CPC_XOVER_AUTO
                                : xover_act_reg;
    config_out.tx_disable =
      ctrl_reg[cpc_pkg::CPC_BIT_TX_DISABLE];
    config_out.power_down = powered_down;
    config_out.polarity_fix_disable =
      ctrl_reg[cpc_pkg::CPC_BIT_POL_DISABLE];
    config_out.jabber_enable =
      ~ctrl_reg[cpc_pkg::CPC_BIT_NO_JABBER] & link_is_10_half;
  end

  assign link_up = config_out.force_link_good | link_state_up;
  assign port_powered_down  = powered_down;
  assign soft_reset_pulse   = do_soft_reset;
  assign aneg_restart_pulse = wake_pulse_reg;

endmodule : cpc_copper_control

// ---- verification/cpc_monitor.sv ----
module cpc_monitor (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Register port
  input wire logic [4:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_write,
  // Link state
  input wire logic                    link_is_gigabit,
  input wire logic                    link_is_10_half,
  // Outputs
  input wire cpc_pkg::cpc_config_type config_out,
  input wire logic                    port_powered_down,
  input wire logic                    soft_reset_pulse,
  input wire logic                    aneg_restart_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  logic       wr;
  // Writes before strap capture are dropped, so skip them
  always_comb age_next = (&age_reg) ? age_reg : age_reg + 3'h1;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) age_reg <= 3'h0;
    else age_reg <= age_next;
  assign wr = reg_write && (&age_reg)
    && reg_addr == cpc_pkg::CPC_OFFSET_CTRL_ONE;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence wake_s;
    $fell(port_powered_down);
  endsequence
  sequence restart_s;
    soft_reset_pulse && aneg_restart_pulse;
  endsequence
  a_pulse_follows: assert property (wr |=>
    config_out.link_pulse_enable == !$past(reg_wdata[15]))
    else $error("link pulse enable wrong after write");
  a_tx_follows: assert property (wr |=>
    config_out.tx_disable == $past(reg_wdata[3]))
    else $error("tx disable wrong after write");
  a_pol_follows: assert property (wr |=>
    config_out.polarity_fix_disable == $past(reg_wdata[1]))
    else $error("polarity disable wrong after write");
  a_gig_no_force: assert property (
    link_is_gigabit |-> !config_out.force_link_good)
    else $error("link forced in gigabit mode");
  a_jabber_mode: assert property (
    !link_is_10_half |-> !config_out.jabber_enable)
    else $error("jabber active outside 10 half");
  a_power_write: assert property (
    wr && reg_wdata[2] |=> port_powered_down)
    else $error("power down bit not obeyed");
  a_wake_restart: assert property (wake_s |=> restart_s)
    else $error("no reset and restart on wake");
  a_update_hold: assert property (
    (&age_reg) && !soft_reset_pulse |=> $stable({
      config_out.downshift_attempts, config_out.downshift_enable,
      config_out.crossover_mode}))
    else $error("update field moved without soft reset");
endmodule : cpc_monitor

bind cpc_copper_control cpc_monitor i_mon (
  .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .link_is_gigabit,
  .link_is_10_half, .config_out, .port_powered_down, .soft_reset_pulse,
  .aneg_restart_pulse
);

// ---- verification/cpc_mgmt_model.sv ----
module cpc_mgmt_model (
  // Clock
  input wire logic        clk,
  // Register port
  output logic [4:0]      reg_addr,
  output logic [15:0]     reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d & 16'hffef;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
endmodule : cpc_mgmt_model

// ---- verification/tb_cpc_copper_control.sv ----
module tb_cpc_copper_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] OFS = cpc_pkg::CPC_OFFSET_CTRL_ONE;
  logic                    clk, sys_rst, reg_write, reg_read, seen;
  logic [4:0]              reg_addr;
  logic [15:0]             reg_wdata, reg_rdata, q;
  logic                    cable_sleep_inhibit_strap, auto_crossover_strap;
  logic                    base_power_down, soft_reset_request;
  logic                    link_is_gigabit, link_is_10_half, link_state_up;
  cpc_pkg::cpc_config_type config_out;
  logic                    link_up, port_powered_down;
  logic                    soft_reset_pulse, aneg_restart_pulse;
  int                      n_fail, tests_run, cycles;
  cpc_mgmt_model i_mgmt (
    .clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata
  );
  cpc_copper_control i_dut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .cable_sleep_inhibit_strap, .auto_crossover_strap,
    .base_power_down, .soft_reset_request, .link_is_gigabit,
    .link_is_10_half, .link_state_up, .config_out, .link_up,
    .port_powered_down, .soft_reset_pulse, .aneg_restart_pulse
  );
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Whole run needs about 60 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {clk, cable_sleep_inhibit_strap, base_power_down} = '0;
    {soft_reset_request, link_is_gigabit, link_state_up} = '0;
    {sys_rst, auto_crossover_strap, link_is_10_half} = '1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    i_mgmt.rd(OFS, q);
    chk("reset image", 16'h3360, q);
    i_mgmt.rd(5'h11, q);
    chk("unmapped", 16'h0000, q);
    i_mgmt.wr(OFS, 16'hfe8b);
    chk("retain cfg", 16'h1bfa, {1'b0, config_out});
    chk("forced link", 16'h0001, {15'h0000, link_up});
    @(posedge clk);
    soft_reset_request <= 1'b1;
    link_is_gigabit <= 1'b1;
    @(posedge clk);
    soft_reset_request <= 1'b0;
    #1;
    chk("update cfg", 16'h7d4a, {1'b0, config_out});
    chk("gig link", 16'h0000, {15'h0000, link_up});
    i_mgmt.rd(OFS, q);
    chk("after reset", 16'h7e8b, q);
    i_mgmt.wr(OFS, 16'h7a8f);
    chk("pd bit", 16'h0001, {15'h0000, port_powered_down});
    @(posedge clk);
    base_power_down <= 1'b1;
    // Let the base bit pass its synchroniser before bit 2 clears
    repeat (5) @(posedge clk);
    i_mgmt.wr(OFS, 16'h7a8b);
    chk("pd base", 16'h0001, {15'h0000, port_powered_down});
    @(posedge clk);
    base_power_down <= 1'b0;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (soft_reset_pulse && aneg_restart_pulse) seen = 1'b1;
    end
    chk("wake", 16'h0001, {15'h0000, seen});
    sys_rst <= 1'b1;
    {cable_sleep_inhibit_strap, auto_crossover_strap} <= 2'b10;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    i_mgmt.rd(OFS, q);
    chk("strap image", 16'h3020, q);
    conclude();
  end
endmodule : tb_cpc_copper_control
